// file: pkg/evt_cfg.svh
// register offsets, field positions and fixed values of the event timer block
`ifndef EVT_CFG_SVH
`define EVT_CFG_SVH

// memory window placement
`define EVT_BASE_ADDR 32'hFED00000
`define EVT_WIN_LSB 10
`define EVT_OFF_W 10

// global registers, byte offsets inside the window
`define EVT_OFF_CAP 10'h000
`define EVT_OFF_GCFG 10'h010
`define EVT_OFF_ISR 10'h020
`define EVT_OFF_CNT_LO 10'h0F0
`define EVT_OFF_CNT_HI 10'h0F4

// per-timer block: 0x100 + 0x20 * timer
`define EVT_TBLK_TAG 3'h2
`define EVT_TREG_CFG 5'h00
`define EVT_TREG_RCAP 5'h04
`define EVT_TREG_CMP_LO 5'h08
`define EVT_TREG_CMP_HI 5'h0C

// global configuration bits
`define EVT_GLOBAL_COUNT_ENABLE 0
`define EVT_LEGACY_ROUTE_ENABLE 1

// timer configuration bits
`define EVT_TCFG_LEVEL 1
`define EVT_TCFG_INTEN 2
`define EVT_TCFG_PER 3
`define EVT_TCFG_PERCAP 4
`define EVT_TCFG_SIZE64 5
`define EVT_TCFG_VSET 6
`define EVT_TCFG_RT_LSB 9
`define EVT_TCFG_RT_MSB 13

// capability word: three timers, 64-bit counter, legacy routing capable
`define EVT_CAP_VALUE 32'h0000A201

// fixed legacy mapping onto the advanced controller inputs
`define EVT_LEG_T0_APIC 2
`define EVT_LEG_T1_APIC 8

// reset values and the all-ones word for low-word wrap detection
`define EVT_CNT_RST 64'h0000000000000000
`define EVT_WORD_ZERO 32'h00000000
`define EVT_ALL_ONES32 32'hFFFFFFFF

`endif

// file: pkg/evt_pkg.sv
// types and helpers shared by the event timer block
package evt_pkg;

   // per-timer software configuration
   typedef struct packed {
      logic [4:0] route;
      logic value_set;
      logic periodic;
      logic int_en;
      logic level;
   } evt_tcfg_s;

   // one comparator write from the bus
   typedef struct packed {
      logic lo;
      logic hi;
      logic [3:0] sel;
      logic [31:0] data;
   } evt_cmpwr_s;

   // byte-lane merge of a bus write into an old word
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0] sel);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
            res[b*8 +: 8] = new_w[b*8 +: 8];
      end
      return res;
   endfunction

endpackage

// file: hdl/evt_comparator.sv
// one timer comparator with optional periodic reload
`timescale 1ns/1ns
`default_nettype none

module evt_comparator #(
   parameter int WIDTH = 64,
   parameter bit PERIODIC = 1'b1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // main counter view
   input wire logic [63:0] cnt_i,
   input wire logic tick_i,
   input wire logic wrap_i,
   // software side
   input wire evt_pkg::evt_tcfg_s cfg_i,
   input wire evt_pkg::evt_cmpwr_s wr_i,
   output logic [63:0] cmp_o,
   output logic fire_o,
   output logic vs_done_o
);

   if (WIDTH != 32 && WIDTH != 64)
   begin : g_chk
      $error("evt_comparator: WIDTH must be 32 or 64");
   end

   logic [WIDTH-1:0] cmp_reg, cmp_next, per_reg, per_next;
   logic [63:0] cmp_ext, per_ext, cmp_wr, per_wr;
   logic periodic_on, wr_any, direct, match;

   // upper half only exists on the wide comparator
   assign cmp_ext = 64'(cmp_reg);
   assign per_ext = 64'(per_reg);
   assign wr_any = wr_i.lo || (wr_i.hi && WIDTH == 64);
   assign periodic_on = PERIODIC && cfg_i.periodic;
   assign direct = !periodic_on || cfg_i.value_set;
   assign match = tick_i && (cnt_i[WIDTH-1:0] == cmp_reg);
   assign cmp_wr = wr_i.hi ?
      {evt_pkg::merge_bytes(cmp_ext[63:32], wr_i.data, wr_i.sel), cmp_ext[31:0]} :
      {cmp_ext[63:32], evt_pkg::merge_bytes(cmp_ext[31:0], wr_i.data, wr_i.sel)};
   assign per_wr = wr_i.hi ?
      {evt_pkg::merge_bytes(per_ext[63:32], wr_i.data, wr_i.sel), per_ext[31:0]} :
      {per_ext[63:32], evt_pkg::merge_bytes(per_ext[31:0], wr_i.data, wr_i.sel)};

   // a write always sets the period; it reaches the comparator only when direct
   always_comb
   begin
      cmp_next = cmp_reg;
      per_next = per_reg;
      if (wr_any)
      begin
         per_next = per_wr[WIDTH-1:0];
         if (direct)
            cmp_next = cmp_wr[WIDTH-1:0];
      end
      else if (match && periodic_on)
         cmp_next = cmp_reg + per_reg;
   end

   // comparator and period storage
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cmp_reg <= '1;
         per_reg <= '0;
      end
      else
      begin
         cmp_reg <= cmp_next;
         per_reg <= per_next;
      end
   end

   // narrow timers also fire when the low counter word rolls over
   assign fire_o = match || (WIDTH == 32 && wrap_i && !periodic_on);
   assign cmp_o = cmp_ext;
   assign vs_done_o = wr_any && cfg_i.value_set;

endmodule // evt_comparator

`default_nettype wire

// file: hdl/evt_route.sv
// steering of the three timer lines onto both interrupt controllers
`timescale 1ns/1ns
`default_nettype none
`include "evt_cfg.svh"

module evt_route #(
   parameter int NUM_APIC = 24
) (
   // timer side
   input wire logic [2:0] line_i,
   input wire logic lre_i,
   input wire logic [14:0] route_i,
   input wire logic [95:0] cap_i,
   // controller side
   output logic leg_irq0_o,
   output logic leg_irq8_o,
   output logic [NUM_APIC-1:0] apic_o
);

   // a route-selected input is only driven when the timer reports it as legal; legacy inputs two and eight skip that check
   always_comb
   begin
      logic [4:0] sel;
      sel = '0;
      apic_o = '0;
      leg_irq0_o = 1'b0;
      leg_irq8_o = 1'b0;
      for (int i = 0; i < 3; i++)
      begin
         sel = route_i[i*5 +: 5];
         if ((!lre_i || i == 2) && cap_i[i*32 + int'(sel)]
             && int'(sel) < NUM_APIC)
            apic_o[sel] = apic_o[sel] | line_i[i];
      end
      if (lre_i)
      begin
         leg_irq0_o = line_i[0];
         apic_o[`EVT_LEG_T0_APIC] = apic_o[`EVT_LEG_T0_APIC] | line_i[0];
         leg_irq8_o = line_i[1];
         apic_o[`EVT_LEG_T1_APIC] = apic_o[`EVT_LEG_T1_APIC] | line_i[1];
      end
   end

endmodule // evt_route

`default_nettype wire

// file: hdl/evt_timer_top.sv
// event timer block: main counter, three comparators, routing, bus slave
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "evt_cfg.svh"

module evt_timer_top #(
   parameter int NUM_APIC = 24,
   parameter logic [31:0] ROUTE_CAP0 = 32'h00F00000,
   parameter logic [31:0] ROUTE_CAP1 = 32'h00F00000,
   parameter logic [31:0] ROUTE_CAP2 = 32'h00F00800
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // legacy interrupt controller inputs
   output logic legacy_irq0_o,
   output logic legacy_irq8_o,
   // advanced interrupt controller inputs
   output logic [NUM_APIC-1:0] apic_irq_o,
   // suppression of the old interval timer and clock interrupts
   output logic pit_irq_mute_o,
   output logic rtc_irq_mute_o
);

   // the fixed legacy mapping needs input eight, the route field reaches 31
   if (NUM_APIC < 9 || NUM_APIC > 32)
   begin : g_chk
      $error("evt_timer_top: NUM_APIC must be 9 to 32");
   end

   localparam logic [95:0] ROUTE_CAPS = {ROUTE_CAP2, ROUTE_CAP1, ROUTE_CAP0};
   localparam logic [31:0] BASE = `EVT_BASE_ADDR;

   // bus state
   logic ack_reg, err_reg;
   logic [31:0] dat_reg, rd_data;
   // global configuration
   logic gen_reg, gen_next;
   logic lre_reg, lre_next;
   // main counter
   logic [63:0] cnt_reg, cnt_next;
   // timers
   evt_pkg::evt_tcfg_s tcfg_reg [3];
   evt_pkg::evt_tcfg_s tcfg_next [3];
   logic [2:0] isr_reg, isr_next;
   logic [2:0] pulse_reg, pulse_next;
   logic [2:0] fire, vs_done, evt, line;
   logic [63:0] cmp_val [3];
   evt_pkg::evt_cmpwr_s cmp_wr [3];
   // routed lines before the output flops
   logic leg0_c, leg8_c;
   logic [NUM_APIC-1:0] apic_c;
   logic [14:0] routes;

   // request decode; a request is taken once, the cycle before ack
   wire req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
   wire in_win = wb_adr_i[31:`EVT_WIN_LSB] == BASE[31:`EVT_WIN_LSB];
   wire acc = req && in_win;
   wire bad = req && !in_win;
   wire wr = acc && wb_we_i;
   wire [`EVT_OFF_W-1:0] off = wb_adr_i[`EVT_OFF_W-1:0];

   // register selects
   wire hit_gcfg = off == `EVT_OFF_GCFG;
   wire hit_isr = off == `EVT_OFF_ISR;
   wire hit_clo = off == `EVT_OFF_CNT_LO;
   wire hit_chi = off == `EVT_OFF_CNT_HI;

   // timer register hit for timer n and register code r at offset o;
   // the offset is an argument so continuous assignments see it change
   function automatic logic t_hit(input int n, input logic [4:0] r,
                                  input logic [`EVT_OFF_W-1:0] o);
      return o[9:7] == `EVT_TBLK_TAG && o[6:5] != 2'b11 && o[6:5] == 2'(n) && o[4:0] == r;
   endfunction

   // configuration word as software sees it
   function automatic logic [31:0] tcfg_word(input evt_pkg::evt_tcfg_s c,
                                             input int n);
      logic [31:0] w;
      w = `EVT_WORD_ZERO;
      w[`EVT_TCFG_LEVEL] = c.level;
      w[`EVT_TCFG_INTEN] = c.int_en;
      w[`EVT_TCFG_PER] = c.periodic;
      w[`EVT_TCFG_PERCAP] = n == 0;
      w[`EVT_TCFG_SIZE64] = n == 0;
      w[`EVT_TCFG_VSET] = c.value_set;
      w[`EVT_TCFG_RT_MSB:`EVT_TCFG_RT_LSB] = c.route;
      return w;
   endfunction

   // global enable and legacy routing, byte lane zero
   assign gen_next = (wr && hit_gcfg && wb_sel_i[0]) ? wb_dat_i[`EVT_GLOBAL_COUNT_ENABLE] : gen_reg;
   assign lre_next = (wr && hit_gcfg && wb_sel_i[0]) ? wb_dat_i[`EVT_LEGACY_ROUTE_ENABLE] : lre_reg;

   // single counter; software writes win over counting
   always_comb
   begin
      cnt_next = cnt_reg;
      if (wr && hit_clo)
         cnt_next[31:0] = evt_pkg::merge_bytes(cnt_reg[31:0], wb_dat_i, wb_sel_i);
      else if (wr && hit_chi)
         cnt_next[63:32] = evt_pkg::merge_bytes(cnt_reg[63:32], wb_dat_i, wb_sel_i);
      else if (gen_reg)
         cnt_next = cnt_reg + 64'h0000000000000001;
   end

   // low word about to roll over on this count
   wire wrap32 = gen_reg && cnt_reg[31:0] == `EVT_ALL_ONES32;

   // comparators: timer zero is wide and periodic, the others narrow
   for (genvar i = 0; i < 3; i++)
   begin : g_tmr
      assign cmp_wr[i].lo = wr && t_hit(i, `EVT_TREG_CMP_LO, off);
      assign cmp_wr[i].hi = wr && t_hit(i, `EVT_TREG_CMP_HI, off);
      assign cmp_wr[i].sel = wb_sel_i;
      assign cmp_wr[i].data = wb_dat_i;

      evt_comparator #(
         .WIDTH(i == 0 ? 64 : 32),
         .PERIODIC(i == 0)
      ) u_cmp (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .cnt_i(cnt_reg),
         .tick_i(gen_reg),
         .wrap_i(wrap32),
         .cfg_i(tcfg_reg[i]),
         .wr_i(cmp_wr[i]),
         .cmp_o(cmp_val[i]),
         .fire_o(fire[i]),
         .vs_done_o(vs_done[i])
      );

      assign routes[i*5 +: 5] = tcfg_reg[i].route;
   end

   // configuration writes; periodic and value-set only exist on timer zero
   always_comb
   begin
      logic [31:0] w;
      w = `EVT_WORD_ZERO;
      for (int i = 0; i < 3; i++)
      begin
         tcfg_next[i] = tcfg_reg[i];
         if (wr && t_hit(i, `EVT_TREG_CFG, off))
         begin
            w = evt_pkg::merge_bytes(tcfg_word(tcfg_reg[i], i), wb_dat_i, wb_sel_i);
            tcfg_next[i].level = w[`EVT_TCFG_LEVEL];
            tcfg_next[i].int_en = w[`EVT_TCFG_INTEN];
            tcfg_next[i].periodic = (i == 0) && w[`EVT_TCFG_PER];
            tcfg_next[i].value_set = (i == 0) && w[`EVT_TCFG_VSET];
            tcfg_next[i].route = w[`EVT_TCFG_RT_MSB:`EVT_TCFG_RT_LSB];
         end
         else if (vs_done[i])
            tcfg_next[i].value_set = 1'b0;
      end
   end

   // qualified events: none is raised while the counter is halted
   assign evt[0] = fire[0] && tcfg_reg[0].int_en && gen_reg;
   assign evt[1] = fire[1] && tcfg_reg[1].int_en && gen_reg;
   assign evt[2] = fire[2] && tcfg_reg[2].int_en && gen_reg;

   // status: a new event in the clearing cycle survives the clear
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         isr_next[i] = isr_reg[i];
         if (wr && hit_isr && wb_sel_i[0] && wb_dat_i[i])
            isr_next[i] = 1'b0;
         if (evt[i] && tcfg_reg[i].level)
            isr_next[i] = 1'b1;
         pulse_next[i] = evt[i] && !tcfg_reg[i].level;
      end
   end

   // level lines follow status while counting, edge lines are one-cycle pulses; a pulse
   // from a match taken while enabled is still delivered, else it is lost
   always_comb
   begin
      for (int i = 0; i < 3; i++)
         line[i] = tcfg_reg[i].level ? (gen_reg && isr_reg[i]) : pulse_reg[i];
   end

   evt_route #(
      .NUM_APIC(NUM_APIC)
   ) u_route (
      .line_i(line),
      .lre_i(lre_reg),
      .route_i(routes),
      .cap_i(ROUTE_CAPS),
      .leg_irq0_o(leg0_c),
      .leg_irq8_o(leg8_c),
      .apic_o(apic_c)
   );

   // read mux; unmapped offsets read as zero
   always_comb
   begin
      rd_data = `EVT_WORD_ZERO;
      if (off == `EVT_OFF_CAP)
         rd_data = `EVT_CAP_VALUE;
      else if (hit_gcfg)
      begin
         rd_data[`EVT_GLOBAL_COUNT_ENABLE] = gen_reg;
         rd_data[`EVT_LEGACY_ROUTE_ENABLE] = lre_reg;
      end
      else if (hit_isr)
         rd_data[2:0] = isr_reg;
      else if (hit_clo)
         rd_data = cnt_reg[31:0];
      else if (hit_chi)
         rd_data = cnt_reg[63:32];
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (t_hit(i, `EVT_TREG_CFG, off))
               rd_data = tcfg_word(tcfg_reg[i], i);
            if (t_hit(i, `EVT_TREG_RCAP, off))
               rd_data = ROUTE_CAPS[i*32 +: 32];
            if (t_hit(i, `EVT_TREG_CMP_LO, off))
               rd_data = cmp_val[i][31:0];
            if (t_hit(i, `EVT_TREG_CMP_HI, off))
               rd_data = cmp_val[i][63:32];
         end
      end
   end

   // bus answer: ack one cycle after the request, err outside the window
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
         dat_reg <= `EVT_WORD_ZERO;
      end
      else
      begin
         ack_reg <= acc;
         err_reg <= bad;
         dat_reg <= (acc && !wb_we_i) ? rd_data : `EVT_WORD_ZERO;
      end
   end

   // control and counting state
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         gen_reg <= 1'b0;
         lre_reg <= 1'b0;
         cnt_reg <= `EVT_CNT_RST;
         isr_reg <= 3'h0;
         pulse_reg <= 3'h0;
      end
      else
      begin
         gen_reg <= gen_next;
         lre_reg <= lre_next;
         cnt_reg <= cnt_next;
         isr_reg <= isr_next;
         pulse_reg <= pulse_next;
      end
   end

   // timer configuration
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 3; i++)
            tcfg_reg[i] <= '0;
      end
      else
      begin
         for (int i = 0; i < 3; i++)
            tcfg_reg[i] <= tcfg_next[i];
      end
   end

   // registered interrupt outputs; costs one cycle of latency, avoids glitches
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         legacy_irq0_o <= 1'b0;
         legacy_irq8_o <= 1'b0;
         apic_irq_o <= '0;
         pit_irq_mute_o <= 1'b0;
         rtc_irq_mute_o <= 1'b0;
      end
      else
      begin
         legacy_irq0_o <= leg0_c;
         legacy_irq8_o <= leg8_c;
         apic_irq_o <= apic_c;
         pit_irq_mute_o <= lre_reg;
         rtc_irq_mute_o <= lre_reg;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_err_o = err_reg;
   assign wb_dat_o = dat_reg;

endmodule // evt_timer_top

`default_nettype wire

// file: sim/evt_timer_top_sva.sv
// port-level assertion checker for the event timer block
`timescale 1ns/1ns
`default_nettype none

module evt_timer_chk #(
   parameter int NUM_APIC = 24,
   parameter logic [31:0] ROUTE_CAP1 = 32'h00000000,
   parameter logic [31:0] ROUTE_CAP2 = 32'h00000000
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   // interrupt lines
   input wire logic legacy_irq0_o,
   input wire logic legacy_irq8_o,
   input wire logic [NUM_APIC-1:0] apic_irq_o,
   input wire logic pit_irq_mute_o,
   input wire logic rtc_irq_mute_o
);
   logic take;
   logic in_win;
   logic gcfg_wr;
   logic [2:0] en_hist_reg;

   // request decode, window is the 1K block at the base
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign in_win = wb_adr_i[31:10] == 22'h3FB400;
   assign gcfg_wr = take && wb_we_i && in_win && wb_adr_i[9:0] == 10'h010 && wb_sel_i[0];

   // shadow of the enable, delayed to cover the two-stage output pipe
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         en_hist_reg <= 3'h0;
      else
         en_hist_reg <= {en_hist_reg[1:0], gcfg_wr ? wb_dat_i[0] : en_hist_reg[0]};
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_err_outside: assert property (take && !in_win |=> wb_err_o && !wb_ack_o)
      else $error("no error answer outside window");
   a_ack_inside: assert property (take && in_win |=> wb_ack_o && !wb_err_o)
      else $error("no ack inside window");
   a_mute_pair: assert property (pit_irq_mute_o == rtc_irq_mute_o)
      else $error("mute outputs disagree");
   a_leg_quiet: assert property (!pit_irq_mute_o && !$past(pit_irq_mute_o)
      |-> !legacy_irq0_o && !legacy_irq8_o)
      else $error("legacy line active without legacy routing");
   a_leg0_apic: assert property (legacy_irq0_o |-> apic_irq_o[2])
      else $error("timer zero legacy line without advanced input two");
   a_leg8_apic: assert property (legacy_irq8_o |-> apic_irq_o[8])
      else $error("timer one legacy line without advanced input eight");
   a_halt_quiet: assert property (en_hist_reg == 3'h0
      |-> apic_irq_o == '0 && !legacy_irq0_o && !legacy_irq8_o)
      else $error("interrupt while counting halted");
   a_rcap_one: assert property (take && !wb_we_i && wb_adr_i == 32'hFED00124
      |=> wb_dat_o == ROUTE_CAP1)
      else $error("timer one capability read wrong");
   a_rcap_two: assert property (take && !wb_we_i && wb_adr_i == 32'hFED00144
      |=> wb_dat_o == ROUTE_CAP2)
      else $error("timer two capability read wrong");
   a_noper_tx: assert property (take && !wb_we_i
      && (wb_adr_i == 32'hFED00120 || wb_adr_i == 32'hFED00140) |=> !wb_dat_o[3])
      else $error("periodic bit set on a one-shot timer");
endmodule // evt_timer_chk

`default_nettype wire

// file: sim/evt_irq_sink.sv
// model of the interrupt controllers: counts rising edges per input
`timescale 1ns/1ns
`default_nettype none

module evt_irq_sink #(
   parameter int NUM_APIC = 24
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // timer lines
   input wire logic irq0_i,
   input wire logic irq8_i,
   input wire logic [NUM_APIC-1:0] apic_i,
   // edge counts
   output var int t0_o,
   output var int l0_o,
   output var int l8_o,
   output var int a8_o,
   output var int a20_o
);
   logic [4:0] prev_reg;
   logic [4:0] now;

   // each input owns its counter, no line is shared
   assign now = {apic_i[20], apic_i[8], irq8_i, irq0_i, apic_i[2]};

   // rising edge counting, like an edge-sensitive controller input
   always_ff @(posedge clk_i)
   begin
      prev_reg <= rst_i ? 5'h00 : now;
      if (rst_i)
      begin
         t0_o <= 0;
         l0_o <= 0;
         l8_o <= 0;
         a8_o <= 0;
         a20_o <= 0;
      end
      else
      begin
         t0_o <= t0_o + int'(now[0] && !prev_reg[0]);
         l0_o <= l0_o + int'(now[1] && !prev_reg[1]);
         l8_o <= l8_o + int'(now[2] && !prev_reg[2]);
         a8_o <= a8_o + int'(now[3] && !prev_reg[3]);
         a20_o <= a20_o + int'(now[4] && !prev_reg[4]);
      end
   end
endmodule // evt_irq_sink

`default_nettype wire

// file: sim/tb_event_timer_periodic_routing.sv
// self-checking bench for the event timer block
`timescale 1ns/1ns
`default_nettype none
`include "evt_cfg.svh"

module tb_event_timer_periodic_routing;
   localparam logic [31:0] BASE = `EVT_BASE_ADDR;
   localparam longint P = 64;
   localparam longint Q = 48;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [31:0] adr = 32'h00000000;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h00000000;
   logic [31:0] dat_o;
   logic ack, err, l0, l8, pit, rtc;
   logic [23:0] apic;
   int t0_n, l0_n, l8_n, a8_n, a20_n;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   integer seed = 32'h0d09618f;
   logic [31:0] rd;
   logic e;
   longint n, n2, m, c;

   always #5 clk_i = ~clk_i;

   evt_timer_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .wb_err_o(err), .legacy_irq0_o(l0), .legacy_irq8_o(l8),
      .apic_irq_o(apic), .pit_irq_mute_o(pit), .rtc_irq_mute_o(rtc));
   evt_irq_sink i_sink (.clk_i(clk_i), .rst_i(rst_i), .irq0_i(l0), .irq8_i(l8),
      .apic_i(apic), .t0_o(t0_n), .l0_o(l0_n), .l8_o(l8_n), .a8_o(a8_n), .a20_o(a20_n));

   // verdict and end of run
   task test_done();
      $display("checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // one classic cycle, whole aligned words only
   task wb(input logic w, input logic [11:0] off, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= BASE + {20'h00000, off};
      sel <= 4'hF;
      dat <= d;
      @(posedge clk_i);
      while (!(ack === 1'b1 || err === 1'b1))
         @(posedge clk_i);
      rd = dat_o;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task wait_n(input int k);
      repeat (k) @(posedge clk_i);
   endtask

   // hang guard, the whole run needs about a thousand cycles
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         test_done();
      end
   end

   // main sequence
   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, 12'h124, 0); chk(rd, 32'h00F00000);
      wb(0, 12'h144, 0); chk(rd, 32'h00F00800);
      wb(1, 12'h400, 0); chk(e, 1);
      wb(0, 12'h3FC, 0); chk({e, rd}, 0);
      wb(1, 12'h120, 32'h8); wb(0, 12'h120, 0); chk(rd[3], 0);
      c = $random(seed);
      wb(1, 12'h0F0, c[31:0]); wait_n(5); wb(0, 12'h0F0, 0); chk(rd, c[31:0]);
      // halt, clear counter, load comparator half by half, restart
      wb(1, 12'h010, 0); wb(1, 12'h0F0, 0); wb(1, 12'h0F4, 0);
      wb(1, 12'h100, 32'h4C); wb(1, 12'h108, P);
      wb(1, 12'h100, 32'h4C); wb(1, 12'h10C, 0);
      wb(0, 12'h100, 0); chk(rd[6], 0);
      wb(0, 12'h108, 0); chk(rd, P);
      wb(1, 12'h010, 3); wait_n(5 * P); wb(1, 12'h010, 2);
      wb(0, 12'h0F0, 0); c = rd; n = t0_n;
      wb(0, 12'h108, 0); chk(rd, (n + 1) * P);
      chk(l0_n, n);
      chk(c >= n * P && c <= (n + 1) * P && n >= 4, 1);
      wb(0, 12'h0F0, 0); chk(rd, c);
      // new period written while halted takes effect after next match
      m = (n + 1) * P;
      wb(1, 12'h108, Q); wb(0, 12'h108, 0); chk(rd, m);
      wb(1, 12'h010, 3); wait_n(4 * Q); wb(1, 12'h010, 2);
      n2 = t0_n - n;
      wb(0, 12'h108, 0); chk(rd, m + n2 * Q);
      n = t0_n; wait_n(50); chk(t0_n, n);
      // comparator sum wraps through zero
      wb(1, 12'h010, 0); wb(1, 12'h0F0, 32'hFFFFFFE0); wb(1, 12'h0F4, 32'hFFFFFFFF);
      wb(1, 12'h100, 32'h4C); wb(1, 12'h108, 32'hFFFFFFF0);
      wb(1, 12'h100, 32'h4C); wb(1, 12'h10C, 32'hFFFFFFFF);
      wb(1, 12'h108, 32'h20); wb(1, 12'h10C, 0);
      wb(1, 12'h010, 1); wait_n(25); wb(1, 12'h010, 0);
      wb(0, 12'h108, 0); chk(rd, 32'h10);
      wb(0, 12'h10C, 0); chk(rd, 0);
      // level line on a routed input, legacy routing masked meanwhile
      wb(1, 12'h0F0, 0); wb(1, 12'h0F4, 0);
      wb(1, 12'h120, 32'h2806); wb(1, 12'h128, 32'h10);
      wb(1, 12'h010, 1); wait_n(40);
      chk(apic[20], 1); chk(a20_n, 1); chk(l8_n, 0);
      wb(0, 12'h020, 0); chk(rd[1], 1);
      wait_n(20); chk(apic[20], 1);
      wb(1, 12'h020, 32'h2); wait_n(3); chk(apic[20], 0);
      // timer one edge mode on legacy routing, never cleared
      wb(1, 12'h120, 32'h4); wb(1, 12'h010, 3);
      repeat (2)
      begin
         wb(0, 12'h0F0, 0); wb(1, 12'h128, rd + 32'h20); wait_n(40);
      end
      chk(l8_n, 2); chk(a8_n, 2);
      test_done();
   end
endmodule // tb_event_timer_periodic_routing

bind evt_timer_top evt_timer_chk #(.NUM_APIC(NUM_APIC), .ROUTE_CAP1(ROUTE_CAP1),
   .ROUTE_CAP2(ROUTE_CAP2)) i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .legacy_irq0_o(legacy_irq0_o), .legacy_irq8_o(legacy_irq8_o), .apic_irq_o(apic_irq_o),
   .pit_irq_mute_o(pit_irq_mute_o), .rtc_irq_mute_o(rtc_irq_mute_o));

`default_nettype wire
